// ---- pirc_pkg.sv ----
package pirc_pkg;

  // Device register map
  localparam logic [7:0] PIRC_FLAGS_OFF = 8'h0C;
  localparam logic [7:0] PIRC_ENABLES_OFF = 8'h8C;
  localparam logic [7:0] PIRC_POWER_OFF = 8'h8E;

  // Flag and enable bit positions
  localparam int PIRC_ADC_BIT = 6;
  localparam int PIRC_SERIAL_BIT = 3;
  localparam int PIRC_CCP_BIT = 2;
  localparam int PIRC_TMR2_BIT = 1;
  localparam int PIRC_TMR1_BIT = 0;
  localparam logic [7:0] PIRC_IMPL_MASK = 8'h4F;

  // Power control status bit positions
  localparam int PIRC_POR_BIT = 1;
  localparam int PIRC_BOR_BIT = 0;
  localparam logic [7:0] PIRC_POWER_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] PIRC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] PIRC_ENABLES_RESET = 8'h00;
  localparam logic PIRC_POR_RESET = 1'b0;
  localparam logic PIRC_BOR_RESET = 1'b0;

  // Capture/compare unit modes
  localparam logic [1:0] PIRC_CCP_OFF = 2'h0;
  localparam logic [1:0] PIRC_CCP_CAPTURE = 2'h1;
  localparam logic [1:0] PIRC_CCP_COMPARE = 2'h2;
  localparam logic [1:0] PIRC_CCP_PWM = 2'h3;

  // Controller APB map
  localparam logic [7:0] PIRC_CTRL_OFF = 8'h00;
  localparam logic [7:0] PIRC_ACCESS_OFF = 8'h04;
  localparam logic [7:0] PIRC_RDATA_OFF = 8'h08;
  localparam logic [7:0] PIRC_IRQ_STATUS_OFF = 8'h0C;
  localparam logic [7:0] PIRC_IRQ_CLEAR_OFF = 8'h10;
  localparam logic [7:0] PIRC_IRQ_ENABLE_OFF = 8'h14;

  // Controller field positions
  localparam int PIRC_CTRL_GIE_BIT = 0;
  localparam int PIRC_CTRL_PERIPHERAL_IRQ_MASTER_ENABLE_BIT = 1;
  localparam int PIRC_CTRL_BROWNOUT_DETECT_ENABLE_BIT = 2;
  localparam int PIRC_ACC_WDATA_LSB = 8;
  localparam int PIRC_ACC_WRITE_BIT = 16;
  localparam int PIRC_RDATA_BUSY_BIT = 8;
  localparam int PIRC_IRQ_DONE_BIT = 0;
  localparam int PIRC_IRQ_PERIPH_BIT = 1;
  localparam logic [2:0] PIRC_CTRL_RESET = 3'h0;
  localparam logic [1:0] PIRC_IRQ_RESET = 2'h0;

  typedef enum logic [1:0] {
    PIRC_IDLE,
    PIRC_ISSUE,
    PIRC_CAPTURE
  } pirc_state_t;

endpackage

// ---- pirc_if.sv ----
`timescale 1ns/1ps
interface pirc_if;
  // Core register port
  logic [7:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  // Peripheral events
  logic adc_done;
  logic serial_done;
  logic ccp_event;
  logic [1:0] ccp_mode;
  logic timer2_match;
  logic timer1_overflow;
  // Reset causes and configuration
  logic brownout_reset;
  logic master_clear_reset;
  logic watchdog_reset;
  logic brownout_detect_enable;
  // Interrupt gating
  logic global_irq_enable;
  logic peripheral_irq_master_enable;
  logic core_irq;

  modport dev (
    input reg_addr, reg_wr, reg_rd, reg_wdata,
    output reg_rdata,
    input adc_done, serial_done, ccp_event, ccp_mode, timer2_match, timer1_overflow,
    input brownout_reset, master_clear_reset, watchdog_reset, brownout_detect_enable,
    input global_irq_enable, peripheral_irq_master_enable,
    output core_irq
  );

  modport core (
    output reg_addr, reg_wr, reg_rd, reg_wdata,
    input reg_rdata,
    output adc_done, serial_done, ccp_event, ccp_mode, timer2_match, timer1_overflow,
    output brownout_reset, master_clear_reset, watchdog_reset, brownout_detect_enable,
    output global_irq_enable, peripheral_irq_master_enable,
    input core_irq
  );
endinterface

// ---- pirc_device.sv ----
// Contract
// - Enable bits 6,3,2,1,0 are read/write
// - Enable bit 1 masks timer2 match
// - Bits 7,5,4 read zero, ignore writes
// - Flags set regardless of any enable
// - Software clears flag before enabling source
// - Conversion done sets flag bit 6
// - Serial transfer done sets flag bit 3
// - Timer2 period match sets flag bit 1
// - Peripheral master enable gates all sources
// - Global enable gates every interrupt
// - Status bit separates power-on from others
// - Brownout bit separates brownout from power-on
// - Brownout bit undefined after power-on
// - Software sets it; brownout clears it
// - Brownout bit meaningless when detector disabled
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module pirc_device
  import pirc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Core side
  pirc_if.dev link
);

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  // Unimplemented bits are dropped on write and on read
  function automatic logic [7:0] impl_only(input logic [7:0] value);
    impl_only = value & PIRC_IMPL_MASK;
  endfunction

  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] enables_reg;
  logic [7:0] enables_next;
  logic por_status_reg;
  logic por_status_next;
  logic bor_status_reg;
  logic bor_status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Register decode
  wire hit_flags = addr_hit(link.reg_addr, PIRC_FLAGS_OFF);
  wire hit_enables = addr_hit(link.reg_addr, PIRC_ENABLES_OFF);
  wire hit_power = addr_hit(link.reg_addr, PIRC_POWER_OFF);
  wire wr_flags = link.reg_wr && hit_flags;
  wire wr_enables = link.reg_wr && hit_enables;
  wire wr_power = link.reg_wr && hit_power;
  // Read strobes; a read with no hit returns zero
  wire rd_flags = link.reg_rd && hit_flags;
  wire rd_enables = link.reg_rd && hit_enables;
  wire rd_power = link.reg_rd && hit_power;

  // A disabled detector raises no brownout at all
  wire bor_hit = link.brownout_reset && link.brownout_detect_enable;

  // Any non power-on reset returns flags and enables to idle
  wire soft_reset = bor_hit || link.master_clear_reset || link.watchdog_reset;

  // Capture/compare only counts outside PWM and off modes
  wire ccp_in_capture = (link.ccp_mode == PIRC_CCP_CAPTURE);
  wire ccp_in_compare = (link.ccp_mode == PIRC_CCP_COMPARE);
  wire ccp_counts = ccp_in_capture || ccp_in_compare;

  // Event vector in flag layout
  logic [7:0] event_bits;
  always_comb begin
    event_bits = 8'h00;
    event_bits[PIRC_ADC_BIT] = link.adc_done;
    event_bits[PIRC_SERIAL_BIT] = link.serial_done;
    event_bits[PIRC_CCP_BIT] = link.ccp_event && ccp_counts;
    event_bits[PIRC_TMR2_BIT] = link.timer2_match;
    event_bits[PIRC_TMR1_BIT] = link.timer1_overflow;
  end

  // Software value of the flags for this cycle
  wire [7:0] flags_base = wr_flags ? link.reg_wdata : flags_reg;
  // Events win over a clearing write in the same cycle
  wire [7:0] flags_merged = impl_only(flags_base | event_bits);

  // A non power-on reset beats any event
  always_comb begin
    if (soft_reset) begin
      flags_next = PIRC_FLAGS_RESET;
    end else begin
      flags_next = flags_merged;
    end
  end

  // Enables are plain storage for implemented bits
  always_comb begin
    if (soft_reset) begin
      enables_next = PIRC_ENABLES_RESET;
    end else if (wr_enables) begin
      enables_next = impl_only(link.reg_wdata);
    end else begin
      enables_next = enables_reg;
    end
  end

  // Power-on status survives master-clear and watchdog resets
  always_comb begin
    if (wr_power) begin
      por_status_next = link.reg_wdata[PIRC_POR_BIT];
    end else begin
      por_status_next = por_status_reg;
    end
  end

  // Brownout clear dominates a software set in the same cycle
  always_comb begin
    if (bor_hit) begin
      bor_status_next = 1'b0;
    end else if (wr_power) begin
      bor_status_next = link.reg_wdata[PIRC_BOR_BIT];
    end else begin
      bor_status_next = bor_status_reg;
    end
  end

  // Named status bits; brownout bit is only trusted once software set it
  wire power_on_status = por_status_reg;
  wire brownout_reset_status = bor_status_reg;

  // Power status in register layout
  logic [7:0] power_view;
  always_comb begin
    power_view = 8'h00;
    power_view[PIRC_POR_BIT] = power_on_status;
    power_view[PIRC_BOR_BIT] = brownout_reset_status;
  end

  // Read data holds between reads; unmapped addresses read zero
  always_comb begin
    if (rd_flags) begin
      rdata_next = impl_only(flags_reg);
    end else if (rd_enables) begin
      rdata_next = impl_only(enables_reg);
    end else if (rd_power) begin
      rdata_next = power_view & PIRC_POWER_MASK;
    end else if (link.reg_rd) begin
      rdata_next = 8'h00;
    end else begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg <= PIRC_FLAGS_RESET;
      enables_reg <= PIRC_ENABLES_RESET;
      rdata_reg <= 8'h00;
    end else begin
      flags_reg <= flags_next;
      enables_reg <= enables_next;
      rdata_reg <= rdata_next;
    end
  end

  // Power-on clears the power-on bit; the brownout bit is left
  // at a fixed zero since its power-on value has no meaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_status_reg <= PIRC_POR_RESET;
      bor_status_reg <= PIRC_BOR_RESET;
    end else begin
      por_status_reg <= por_status_next;
      bor_status_reg <= bor_status_next;
    end
  end

  assign link.reg_rdata = rdata_reg;

  // Named flag fields
  wire converter_done_flag = flags_reg[PIRC_ADC_BIT];
  wire serial_port_flag = flags_reg[PIRC_SERIAL_BIT];
  wire capture_compare_flag = flags_reg[PIRC_CCP_BIT];
  wire timer2_match_flag = flags_reg[PIRC_TMR2_BIT];
  wire timer1_overflow_flag = flags_reg[PIRC_TMR1_BIT];

  // Named enable fields
  wire converter_done_irq_enable = enables_reg[PIRC_ADC_BIT];
  wire serial_port_irq_enable = enables_reg[PIRC_SERIAL_BIT];
  wire capture_compare_irq_enable = enables_reg[PIRC_CCP_BIT];
  wire timer2_match_irq_enable = enables_reg[PIRC_TMR2_BIT];
  wire timer1_overflow_irq_enable = enables_reg[PIRC_TMR1_BIT];

  // Per-source requests; a stale flag fires the moment its enable is set
  wire converter_done_req = converter_done_flag && converter_done_irq_enable;
  wire serial_port_req = serial_port_flag && serial_port_irq_enable;
  wire capture_compare_req = capture_compare_flag && capture_compare_irq_enable;
  wire timer2_match_req = timer2_match_flag && timer2_match_irq_enable;
  wire timer1_overflow_req = timer1_overflow_flag && timer1_overflow_irq_enable;

  // Interrupt request, gated by both master enables
  wire any_pending = converter_done_req || serial_port_req || capture_compare_req ||
                     timer2_match_req || timer1_overflow_req;
  wire periph_gate = link.peripheral_irq_master_enable;
  wire global_gate = link.global_irq_enable;

  assign link.core_irq = any_pending && periph_gate && global_gate;

endmodule

// ---- pirc_core.sv ----
`timescale 1ns/1ps
module pirc_core
  import pirc_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // Peripheral events
  input wire logic adc_done,
  input wire logic serial_done,
  input wire logic ccp_event,
  input wire logic [1:0] ccp_mode,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  // Reset causes
  input wire logic brownout_reset,
  input wire logic master_clear_reset,
  input wire logic watchdog_reset,
  // Device side
  pirc_if.core link
);

  pirc_state_t state_reg;
  pirc_state_t state_next;
  logic [2:0] ctrl_reg;
  logic [16:0] access_reg;
  logic [7:0] rdata_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_enable_reg;
  logic core_irq_reg;
  logic [31:0] prdata_reg;

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = (paddr == PIRC_CTRL_OFF);
  wire hit_access = (paddr == PIRC_ACCESS_OFF);
  wire hit_rdata = (paddr == PIRC_RDATA_OFF);
  wire hit_status = (paddr == PIRC_IRQ_STATUS_OFF);
  wire hit_clear = (paddr == PIRC_IRQ_CLEAR_OFF);
  wire hit_enable = (paddr == PIRC_IRQ_ENABLE_OFF);
  wire mapped = hit_ctrl || hit_access || hit_rdata || hit_status || hit_clear || hit_enable;
  wire busy = (state_reg != PIRC_IDLE);
  wire do_write = access && pwrite && mapped;
  // A launch while busy is dropped rather than queued
  wire launch = do_write && hit_access && !busy;

  // Read mux, sampled in the setup cycle so prdata is a flop
  logic [31:0] read_word;
  always_comb begin
    read_word = 32'h0000_0000;
    if (hit_ctrl) begin
      read_word[2:0] = ctrl_reg;
    end else if (hit_access) begin
      read_word[16:0] = access_reg;
    end else if (hit_rdata) begin
      read_word[7:0] = rdata_reg;
      read_word[PIRC_RDATA_BUSY_BIT] = busy;
    end else if (hit_status) begin
      read_word[1:0] = irq_status_reg;
    end else if (hit_enable) begin
      read_word[1:0] = irq_enable_reg;
    end
  end

  assign pready = access;
  assign pslverr = access && !mapped;
  assign prdata = prdata_reg;

  // Device access sequencer
  always_comb begin
    case (state_reg)
      PIRC_IDLE: state_next = launch ? PIRC_ISSUE : PIRC_IDLE;
      PIRC_ISSUE: state_next = PIRC_CAPTURE;
      default: state_next = PIRC_IDLE;
    endcase
  end

  wire issuing = (state_reg == PIRC_ISSUE);
  wire done_evt = (state_reg == PIRC_CAPTURE);
  wire periph_evt = link.core_irq && !core_irq_reg;
  wire [1:0] irq_events = {periph_evt, done_evt};
  wire [1:0] irq_clear = (do_write && hit_clear) ? pwdata[1:0] : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= PIRC_IDLE;
      ctrl_reg <= PIRC_CTRL_RESET;
      access_reg <= 17'h0_0000;
      rdata_reg <= 8'h00;
      irq_status_reg <= PIRC_IRQ_RESET;
      irq_enable_reg <= PIRC_IRQ_RESET;
      core_irq_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (do_write && hit_ctrl) begin
        ctrl_reg <= pwdata[2:0];
      end
      if (launch) begin
        access_reg <= pwdata[16:0];
      end
      if (done_evt && !access_reg[PIRC_ACC_WRITE_BIT]) begin
        rdata_reg <= link.reg_rdata;
      end
      // New events win over a clear in the same cycle
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      if (do_write && hit_enable) begin
        irq_enable_reg <= pwdata[1:0];
      end
      core_irq_reg <= link.core_irq;
      prdata_reg <= setup ? read_word : 32'h0000_0000;
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // Device register port
  assign link.reg_addr = access_reg[7:0];
  assign link.reg_wdata = access_reg[PIRC_ACC_WDATA_LSB +: 8];
  assign link.reg_wr = issuing && access_reg[PIRC_ACC_WRITE_BIT];
  assign link.reg_rd = issuing && !access_reg[PIRC_ACC_WRITE_BIT];

  // Events and configuration toward the device
  assign link.adc_done = adc_done;
  assign link.serial_done = serial_done;
  assign link.ccp_event = ccp_event;
  assign link.ccp_mode = ccp_mode;
  assign link.timer2_match = timer2_match;
  assign link.timer1_overflow = timer1_overflow;
  assign link.brownout_reset = brownout_reset;
  assign link.master_clear_reset = master_clear_reset;
  assign link.watchdog_reset = watchdog_reset;
  assign link.brownout_detect_enable = ctrl_reg[PIRC_CTRL_BROWNOUT_DETECT_ENABLE_BIT];
  assign link.global_irq_enable = ctrl_reg[PIRC_CTRL_GIE_BIT];
  assign link.peripheral_irq_master_enable = ctrl_reg[PIRC_CTRL_PERIPHERAL_IRQ_MASTER_ENABLE_BIT];

endmodule

// ---- pirc_sva.sv ----
`timescale 1ns/1ps
module pirc_sva
  import pirc_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Events and resets
  input wire logic adc_done,
  input wire logic serial_done,
  input wire logic ccp_event,
  input wire logic [1:0] ccp_mode,
  input wire logic timer2_match,
  input wire logic timer1_overflow,
  input wire logic brownout_reset,
  input wire logic master_clear_reset,
  input wire logic watchdog_reset,
  // Gating
  input wire logic brownout_detect_enable,
  input wire logic global_irq_enable,
  input wire logic peripheral_irq_master_enable,
  input wire logic core_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow copies; set wins over a write of zero, a reset cause wins over all
  logic [7:0] fl_reg;
  logic [7:0] en_reg;
  logic [1:0] pw_reg;
  wire bo_hit = brownout_reset && brownout_detect_enable;
  wire clr_all = bo_hit || master_clear_reset || watchdog_reset;
  wire ccp_hit = ccp_event && (ccp_mode == PIRC_CCP_CAPTURE || ccp_mode == PIRC_CCP_COMPARE);
  wire [7:0] ev = {1'b0, adc_done, 2'b00, serial_done, ccp_hit, timer2_match, timer1_overflow};
  wire wr_fl = reg_wr && reg_addr == PIRC_FLAGS_OFF;
  wire wr_en = reg_wr && reg_addr == PIRC_ENABLES_OFF;
  wire wr_pw = reg_wr && reg_addr == PIRC_POWER_OFF;
  wire [7:0] fl_next = clr_all ? 8'h00 : ((wr_fl ? reg_wdata & PIRC_IMPL_MASK : fl_reg) | ev);
  wire [7:0] en_next = clr_all ? 8'h00 : (wr_en ? reg_wdata & PIRC_IMPL_MASK : en_reg);
  wire pw_por = wr_pw ? reg_wdata[PIRC_POR_BIT] : pw_reg[1];
  wire pw_bor = !bo_hit && (wr_pw ? reg_wdata[PIRC_BOR_BIT] : pw_reg[0]);
  wire [1:0] pw_next = {pw_por, pw_bor};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fl_reg <= 8'h00;
      en_reg <= 8'h00;
      pw_reg <= 2'h0;
    end else begin
      fl_reg <= fl_next;
      en_reg <= en_next;
      pw_reg <= pw_next;
    end
  end
  a_unimpl_zero:
    assert property ((reg_rdata & 8'hB0) == 8'h00)
    else $error("unimplemented bits read nonzero");
  a_flags_read:
    assert property (reg_rd && reg_addr == PIRC_FLAGS_OFF
      |=> reg_rdata == $past(fl_reg))
    else $error("flag register read wrong");
  a_enables_read:
    assert property (reg_rd && reg_addr == PIRC_ENABLES_OFF
      |=> reg_rdata == $past(en_reg))
    else $error("enable register read wrong");
  a_power_read:
    assert property (reg_rd && reg_addr == PIRC_POWER_OFF
      |=> reg_rdata == {6'h00, $past(pw_reg)})
    else $error("power status read wrong");
  a_irq_level:
    assert property (core_irq == (|(fl_reg & en_reg) && global_irq_enable
      && peripheral_irq_master_enable))
    else $error("core interrupt level wrong");
  a_irq_master_gate:
    assert property (!peripheral_irq_master_enable |-> !core_irq)
    else $error("interrupt without peripheral master enable");
  a_irq_global_gate:
    assert property (!global_irq_enable |-> !core_irq)
    else $error("interrupt without global enable");
  a_strobe_single: assert property (reg_wr || reg_rd |=> !reg_wr && !reg_rd)
    else $error("register strobe longer than one cycle");
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import pirc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  // Events {adc, serial, ccp, timer2, timer1}; causes {brownout, master clear, watchdog}
  logic [4:0] ev = 5'h00;
  logic [1:0] ccp_mode = 2'h0;
  logic [2:0] rst_ev = 3'h0;
  logic rd_chk = 1'b0;
  logic [32:0] notes[$];
  logic [31:0] rd;
  logic [7:0] exp_fl;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 42;
  always #4 pclk = ~pclk;
  pirc_if link_if();
  pirc_core pirc_core_inst(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .adc_done(ev[4]), .serial_done(ev[3]), .ccp_event(ev[2]),
    .ccp_mode(ccp_mode), .timer2_match(ev[1]), .timer1_overflow(ev[0]),
    .brownout_reset(rst_ev[2]), .master_clear_reset(rst_ev[1]), .watchdog_reset(rst_ev[0]),
    .link(link_if));
  pirc_device pirc_device_inst(.pclk(pclk), .presetn(presetn), .link(link_if));
  pirc_sva pirc_sva_inst(.pclk(pclk), .presetn(presetn), .reg_addr(link_if.reg_addr),
    .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd), .reg_wdata(link_if.reg_wdata),
    .reg_rdata(link_if.reg_rdata), .adc_done(link_if.adc_done),
    .serial_done(link_if.serial_done), .ccp_event(link_if.ccp_event),
    .ccp_mode(link_if.ccp_mode), .timer2_match(link_if.timer2_match),
    .timer1_overflow(link_if.timer1_overflow), .brownout_reset(link_if.brownout_reset),
    .master_clear_reset(link_if.master_clear_reset), .watchdog_reset(link_if.watchdog_reset),
    .brownout_detect_enable(link_if.brownout_detect_enable),
    .global_irq_enable(link_if.global_irq_enable),
    .peripheral_irq_master_enable(link_if.peripheral_irq_master_enable),
    .core_irq(link_if.core_irq));
  task check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    rd_chk <= c;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    rd_chk <= 1'b0;
    // Return off the edge so callers see the write settled
    @(negedge pclk);
  endtask
  task apb_rd(input logic [7:0] a, input logic [32:0] exp);
    notes.push_back(exp);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  // Device access through the core; polls busy so accesses never overlap
  task dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, PIRC_ACCESS_OFF, {15'h0000, w, d, a}, 1'b0);
    n = 0;
    do begin
      apb(1'b0, PIRC_RDATA_OFF, 32'h0, 1'b0);
      n++;
    end while (rd[PIRC_RDATA_BUSY_BIT] !== 1'b0 && n < 20);
    check("busy", {32'h0, rd[PIRC_RDATA_BUSY_BIT]}, 33'h0);
  endtask
  task dev_rd(input logic [7:0] a, input logic [7:0] exp);
    dev(1'b0, a, 8'h00);
    apb_rd(PIRC_RDATA_OFF, {25'h0, exp});
  endtask
  task pulse(input logic [4:0] v, input logic [2:0] r);
    @(posedge pclk);
    ev <= v;
    rst_ev <= r;
    @(posedge pclk);
    ev <= 5'h00;
    rst_ev <= 3'h0;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (psel && penable && pready === 1'b1 && rd_chk) begin
      check("apb read", {pslverr, prdata}, notes.pop_front());
    end
    // Generous ceiling; the full sequence takes about 450 cycles
    if (cycles == 20000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    int i;
    logic [4:0] v;
    logic [1:0] m;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    dev_rd(PIRC_FLAGS_OFF, PIRC_FLAGS_RESET);
    dev_rd(PIRC_ENABLES_OFF, PIRC_ENABLES_RESET);
    apb_rd(8'h20, {1'b1, 32'h0});
    dev(1'b1, PIRC_ENABLES_OFF, 8'hFF);
    dev_rd(PIRC_ENABLES_OFF, 8'h4F);
    dev(1'b1, PIRC_FLAGS_OFF, 8'hFF);
    dev_rd(PIRC_FLAGS_OFF, 8'h4F);
    for (i = 0; i < 4; i++) begin
      dev(1'b1, PIRC_FLAGS_OFF, 8'h00);
      ccp_mode <= i[1:0];
      pulse(5'h04, 3'h0);
      dev_rd(PIRC_FLAGS_OFF, (i == 1 || i == 2) ? 8'h04 : 8'h00);
    end
    // Sticky flags with global enable off
    dev(1'b1, PIRC_FLAGS_OFF, 8'h00);
    exp_fl = 8'h00;
    for (i = 0; i < 8; i++) begin
      v = 5'($random(seed));
      m = 2'($random(seed));
      ccp_mode <= m;
      pulse(v, 3'h0);
      exp_fl = exp_fl | {1'b0, v[4], 2'b00, v[3], v[2] && (m == 2'h1 || m == 2'h2), v[1], v[0]};
      dev_rd(PIRC_FLAGS_OFF, exp_fl);
    end
    dev(1'b1, PIRC_FLAGS_OFF, 8'h00);
    dev(1'b1, PIRC_ENABLES_OFF, 8'h02);
    apb(1'b1, PIRC_CTRL_OFF, 32'h3, 1'b0);
    apb(1'b1, PIRC_IRQ_CLEAR_OFF, 32'h3, 1'b0);
    apb(1'b1, PIRC_IRQ_ENABLE_OFF, 32'h2, 1'b0);
    pulse(5'h02, 3'h0);
    apb_rd(PIRC_IRQ_STATUS_OFF, {1'b0, 32'h2});
    check("core_irq", {32'h0, link_if.core_irq}, 33'h1);
    check("irq", {32'h0, irq}, 33'h1);
    apb(1'b1, PIRC_IRQ_ENABLE_OFF, 32'h0, 1'b0);
    check("irq masked", {32'h0, irq}, 33'h0);
    apb(1'b1, PIRC_IRQ_CLEAR_OFF, 32'h2, 1'b0);
    apb(1'b1, PIRC_IRQ_ENABLE_OFF, 32'h2, 1'b0);
    check("irq cleared", {32'h0, irq}, 33'h0);
    apb(1'b1, PIRC_CTRL_OFF, 32'h2, 1'b0);
    check("core_irq no global", {32'h0, link_if.core_irq}, 33'h0);
    apb(1'b1, PIRC_CTRL_OFF, 32'h1, 1'b0);
    check("core_irq no master", {32'h0, link_if.core_irq}, 33'h0);
    apb(1'b1, PIRC_CTRL_OFF, 32'h3, 1'b0);
    dev(1'b1, PIRC_ENABLES_OFF, 8'h00);
    check("core_irq masked", {32'h0, link_if.core_irq}, 33'h0);
    // Reset causes against power status
    dev(1'b1, PIRC_POWER_OFF, 8'h03);
    dev_rd(PIRC_POWER_OFF, 8'h03);
    pulse(5'h00, 3'h2);
    dev_rd(PIRC_POWER_OFF, 8'h03);
    dev_rd(PIRC_FLAGS_OFF, 8'h00);
    pulse(5'h00, 3'h4);
    dev_rd(PIRC_POWER_OFF, 8'h03);
    apb(1'b1, PIRC_CTRL_OFF, 32'h7, 1'b0);
    pulse(5'h00, 3'h4);
    dev_rd(PIRC_POWER_OFF, 8'h02);
    dev(1'b1, PIRC_ENABLES_OFF, 8'h4F);
    pulse(5'h00, 3'h1);
    dev_rd(PIRC_ENABLES_OFF, 8'h00);
    give_verdict;
  end
endmodule
